// ---- verilog/pd_wake_pkg.sv ----
// constants for the power-down and wake-up controller
package pd_wake_pkg;
  // register offsets on the plain register port
  localparam logic [7:0] OFS_POWER_CTRL  = 8'h00;
  localparam logic [7:0] OFS_POWER_CTRL2 = 8'h01;
  localparam logic [7:0] OFS_SYSTEM_CTRL = 8'h02;
  localparam logic [7:0] OFS_USB_CLOCK   = 8'h03;
  localparam logic [7:0] OFS_USB_PD      = 8'h04;
  localparam logic [7:0] OFS_STATUS      = 8'h05;
  // field positions
  localparam int BIT_PD_ARM      = 1;
  localparam int BIT_PD_START    = 6;
  localparam int BIT_WAKE_EN     = 7;
  localparam int BIT_WAKE_SRC    = 4;
  localparam int BIT_REG_MAP     = 4;
  localparam int BIT_USB_CLK_EN  = 1;
  localparam int BIT_USB_PLL_EN  = 0;
  localparam int BIT_USB_RX_PD   = 0;
  // values after reset
  localparam logic [7:0] RST_POWER_CTRL  = 8'h00;
  localparam logic [7:0] RST_POWER_CTRL2 = 8'h00;
  localparam logic [7:0] RST_SYSTEM_CTRL = 8'h00;
  localparam logic [7:0] RST_USB_CLOCK   = 8'h03;
  localparam logic [7:0] RST_USB_PD      = 8'h01;
  // power-down wake-up interrupt vector
  localparam logic [15:0] WAKE_VECTOR    = 16'h007B;
  // timing
  localparam int CLK_MHZ      = 200;
  localparam int T_LATCH_US   = 10;
  localparam int LATCH_CYC    = T_LATCH_US * CLK_MHZ;
  localparam int T_SETTLE_MS  = 5;
  localparam int SETTLE_CYC   = T_SETTLE_MS * CLK_MHZ * 1000;
  localparam int T_SUSPEND_MS = 6;
  localparam int SUSPEND_CYC  = T_SUSPEND_MS * CLK_MHZ * 1000;
  localparam int TMR_W        = 21;
  typedef enum logic [2:0] {
    ST_RUN     = 3'b000,
    ST_PD      = 3'b001,
    ST_LATCH   = 3'b010,
    ST_OSC     = 3'b011,
    ST_SETTLE  = 3'b100,
    ST_RESTORE = 3'b101
  } pd_state_t;
endpackage

// ---- verilog/delay_timer.sv ----
// one-shot down counter: done pulses a given number of cycles after start
`timescale 1ns/1ps
module delay_timer #(
  parameter int W = 21
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         start,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] cnt_r;
  logic         run_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (start) begin
      cnt_r <= count - {{(W-1){1'b0}}, 1'b1};
      run_r <= 1'b1;
    end else if (run_r) begin
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      if (cnt_r == '0)
        run_r <= 1'b0;
    end
  end

  assign done = run_r && (cnt_r == '0);
endmodule // delay_timer

// ---- verilog/usb_suspend_det.sv ----
// usb idle watch: suspend after a long idle, wake pulse on renewed activity
`timescale 1ns/1ps
module usb_suspend_det #(
  parameter int W     = 21,
  parameter int LIMIT = 1200000
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic activity,
  input  wire logic rx_enabled,
  output logic      suspend,
  output logic      resume
);
  logic [W-1:0] idle_r;
  logic         susp_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      idle_r <= '0;
      susp_r <= 1'b0;
    end else if (activity) begin
      idle_r <= '0;
      susp_r <= 1'b0;
    end else if (idle_r < W'(LIMIT)) begin
      idle_r <= idle_r + {{(W-1){1'b0}}, 1'b1};
    end else begin
      susp_r <= 1'b1;
    end
  end

  assign suspend = susp_r;
  // a powered-down receiver cannot see the bus, so no trigger
  assign resume  = susp_r && activity && rx_enabled;

  a_suspend_exit: assert property (@(posedge clk_sys) disable iff (sys_rst)
    activity |=> !susp_r) else $error("suspend not left on activity");
endmodule // usb_suspend_det

// ---- verilog/power_down_wakeup_ctrl.sv ----
// power-down entry guard, wake-up sequencer and its registers
//
// Functional notes
// - power-down enters only after an arm write followed by a start write
// - a write setting arm and start together never enters power-down
// - arm and start bits self-clear and always read as zero
// - with wake-up disabled, only hardware reset leaves power-down
// - a low pin latch at entry starts pin wake-up at once
// - usb wake trigger only while usb receiver stays powered
// - usb enters suspend after more than 6 ms without bus activity
// - reset restores registers, restarts both oscillators, ram untouched
// - pin low starts rc oscillator; low held 10 us latch phase
// - after stable oscillator wait 5 ms, then raise wake interrupt at 007B
// - after the wake handler returns, code resumes after the start write
// - timers, serial channel and watchdog frozen until clock restore ends
// - all interrupts blocked from latch phase until handler return
// - usb activity ends suspend and runs the pin wake steps except the latch phase
// - wake source select: zero pin (reset value), one usb
`timescale 1ns/1ps
module power_down_wakeup_ctrl
  import pd_wake_pkg::*;
#(
  parameter int SETTLE_CYCLES  = pd_wake_pkg::SETTLE_CYC,
  parameter int SUSPEND_CYCLES = pd_wake_pkg::SUSPEND_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        ext_wake_pin,
  input  wire logic        ext_wake_latch,
  input  wire logic        usb_bus_activity,
  input  wire logic        osc_stable,
  input  wire logic        wake_reti,
  output logic             cpu_halt,
  output logic             main_osc_en,
  output logic             rc_osc_en,
  output logic             periph_freeze,
  output logic             irq_block,
  output logic             wake_irq,
  output logic      [15:0] wake_vector,
  output logic             usb_suspend,
  output logic             usb_clk_gate
);
  import pd_wake_pkg::*;

  pd_state_t   state_r;
  pd_state_t   state_nxt;
  logic [7:0]  power_ctrl_r;
  logic [7:0]  power_ctrl2_r;
  logic [7:0]  system_ctrl_r;
  logic [7:0]  usb_clock_r;
  logic [7:0]  usb_pd_r;
  logic [7:0]  rdata_r;
  logic        arm_pend_r;
  logic        wake_isr_r;
  logic        wake_irq_r;
  logic        wr_power;
  logic        enter_pd;
  logic        pin_low;
  logic        usb_resume;
  logic        susp;
  logic        tmr_start;
  logic [TMR_W-1:0] tmr_count;
  logic        tmr_done;
  logic        wake_from_pd_en;
  logic        wake_source_sel;
  logic        reg_map_select;
  logic        usb_module_clk_en;
  logic        usb_rx_power_down;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wake_from_pd_en   = power_ctrl2_r[BIT_WAKE_EN];
  assign wake_source_sel   = power_ctrl2_r[BIT_WAKE_SRC];
  assign reg_map_select    = system_ctrl_r[BIT_REG_MAP];
  assign usb_module_clk_en = usb_clock_r[BIT_USB_CLK_EN];
  assign usb_rx_power_down = usb_pd_r[BIT_USB_RX_PD];

  ////////////////////////////////////////////////////////////////////////////
  // entry guard

  assign wr_power = reg_wr && hit(reg_addr, OFS_POWER_CTRL);
  assign enter_pd = (state_r == ST_RUN) && wr_power && arm_pend_r
                    && reg_wdata[BIT_PD_START]
                    && !reg_wdata[BIT_PD_ARM];

  // any write other than a clean arm write drops a pending arm
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      arm_pend_r <= 1'b0;
    end else if (reg_wr) begin
      arm_pend_r <= wr_power && reg_wdata[BIT_PD_ARM]
                    && !reg_wdata[BIT_PD_START];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      power_ctrl_r  <= RST_POWER_CTRL;
      power_ctrl2_r <= RST_POWER_CTRL2;
      system_ctrl_r <= RST_SYSTEM_CTRL;
      usb_clock_r   <= RST_USB_CLOCK;
      usb_pd_r      <= RST_USB_PD;
    end else if (reg_wr) begin
      if (hit(reg_addr, OFS_POWER_CTRL)) begin
        power_ctrl_r <= reg_wdata;
        power_ctrl_r[BIT_PD_ARM]   <= 1'b0;
        power_ctrl_r[BIT_PD_START] <= 1'b0;
      end
      // second power register only reachable under map select
      if (hit(reg_addr, OFS_POWER_CTRL2) && reg_map_select)
        power_ctrl2_r <= reg_wdata;
      if (hit(reg_addr, OFS_SYSTEM_CTRL))
        system_ctrl_r <= reg_wdata;
      if (hit(reg_addr, OFS_USB_CLOCK))
        usb_clock_r <= reg_wdata;
      if (hit(reg_addr, OFS_USB_PD))
        usb_pd_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_POWER_CTRL:  rdata_r <= power_ctrl_r;
        OFS_POWER_CTRL2: rdata_r <= reg_map_select ? power_ctrl2_r : 8'h00;
        OFS_SYSTEM_CTRL: rdata_r <= system_ctrl_r;
        OFS_USB_CLOCK:   rdata_r <= usb_clock_r;
        OFS_USB_PD:      rdata_r <= usb_pd_r;
        OFS_STATUS:      rdata_r <= {3'h0, wake_isr_r, susp, state_r};
        default:         rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // wake-up sequencer

  // a zero port latch pulls the pin low from inside
  assign pin_low = !(ext_wake_pin && ext_wake_latch);

  always_comb begin
    state_nxt = state_r;
    tmr_start = 1'b0;
    tmr_count = TMR_W'(LATCH_CYC);
    case (state_r)
      ST_RUN: begin
        if (enter_pd)
          state_nxt = ST_PD;
      end
      ST_PD: begin
        // without wake enable only sys_rst ends this state
        if (wake_from_pd_en) begin
          if (!wake_source_sel && pin_low) begin
            state_nxt = ST_LATCH;
            tmr_start = 1'b1;
          end else if (wake_source_sel && usb_resume) begin
            state_nxt = ST_OSC;
          end
        end
      end
      ST_LATCH: begin
        if (tmr_done)
          state_nxt = ST_OSC;
      end
      ST_OSC: begin
        if (osc_stable) begin
          state_nxt = ST_SETTLE;
          tmr_start = 1'b1;
          tmr_count = TMR_W'(SETTLE_CYCLES);
        end
      end
      ST_SETTLE: begin
        if (tmr_done)
          state_nxt = ST_RESTORE;
      end
      ST_RESTORE: begin
        // clock restore may also be put off until after the return
        if (usb_module_clk_en || wake_reti)
          state_nxt = ST_RUN;
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      state_r <= ST_RUN;
    else
      state_r <= state_nxt;
  end

  // usb clock stays gated through restore until software enables it
  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      wake_irq_r <= 1'b0;
    else
      wake_irq_r <= (state_r == ST_SETTLE) && tmr_done;
  end

  // handler in progress: return lets the cpu resume after the start write
  always_ff @(posedge clk_sys) begin
    if (sys_rst)
      wake_isr_r <= 1'b0;
    else if (wake_irq_r)
      wake_isr_r <= 1'b1;
    else if (wake_reti)
      wake_isr_r <= 1'b0;
  end

  delay_timer #(
    .W (TMR_W)
  ) u_timer (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .start   (tmr_start),
    .count   (tmr_count),
    .done    (tmr_done)
  );

  usb_suspend_det #(
    .W     (TMR_W),
    .LIMIT (SUSPEND_CYCLES)
  ) u_usb_susp (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .activity   (usb_bus_activity),
    .rx_enabled (!usb_rx_power_down),
    .suspend    (susp),
    .resume     (usb_resume)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign cpu_halt      = (state_r != ST_RUN) && (state_r != ST_RESTORE);
  assign main_osc_en   = (state_r != ST_PD) && (state_r != ST_LATCH);
  assign rc_osc_en     = (state_r != ST_PD);
  assign periph_freeze = (state_r != ST_RUN);
  assign irq_block     = (state_r != ST_RUN) && (state_r != ST_PD)
                         || wake_isr_r;
  assign wake_irq      = wake_irq_r;
  assign wake_vector   = WAKE_VECTOR;
  assign usb_suspend   = susp;
  assign usb_clk_gate  = usb_module_clk_en && (state_r == ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  logic [TMR_W-1:0] latch_obs_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst || state_r != ST_LATCH)
      latch_obs_r <= '0;
    else
      latch_obs_r <= latch_obs_r + {{(TMR_W-1){1'b0}}, 1'b1};
  end

  sequence seq_arm_write;
    reg_wr && hit(reg_addr, OFS_POWER_CTRL) && reg_wdata[BIT_PD_ARM]
      && !reg_wdata[BIT_PD_START] && state_r == ST_RUN;
  endsequence

  sequence seq_start_write;
    reg_wr && hit(reg_addr, OFS_POWER_CTRL) && reg_wdata[BIT_PD_START]
      && !reg_wdata[BIT_PD_ARM];
  endsequence

  a_entry_pair: assert property (
    seq_arm_write ##1 seq_start_write |=> state_r == ST_PD)
    else $error("arm then start did not enter power-down");

  a_no_joint_entry: assert property (
    wr_power && reg_wdata[BIT_PD_ARM] && reg_wdata[BIT_PD_START]
      && state_r == ST_RUN |=> state_r == ST_RUN)
    else $error("joint arm and start entered power-down");

  a_stale_arm: assert property (
    seq_arm_write ##1 (reg_wr && !wr_power) ##1 seq_start_write
      |=> state_r == ST_RUN)
    else $error("stale arm allowed entry");

  a_bits_zero: assert property (
    reg_rd && hit(reg_addr, OFS_POWER_CTRL)
      |=> !reg_rdata[BIT_PD_ARM] && !reg_rdata[BIT_PD_START])
    else $error("arm or start bit read as one");

  a_reset_only: assert property (
    state_r == ST_PD && !wake_from_pd_en |=> state_r == ST_PD)
    else $error("left power-down without wake enable");

  a_usb_gate: assert property (
    state_r == ST_PD && wake_source_sel && usb_rx_power_down
      |=> state_r == ST_PD)
    else $error("usb wake with receiver powered down");

  a_latch_len: assert property (
    state_r == ST_LATCH && state_nxt != ST_LATCH
      |-> latch_obs_r == TMR_W'(LATCH_CYC - 1))
    else $error("latch phase length wrong");

  a_wake_irq: assert property (
    state_r == ST_SETTLE && tmr_done
      |=> wake_irq && state_r == ST_RESTORE ##1 !wake_irq)
    else $error("wake interrupt not raised once");

  a_freeze_hold: assert property (
    state_r == ST_RESTORE && !usb_module_clk_en && !wake_reti
      |=> periph_freeze && state_r == ST_RESTORE)
    else $error("peripherals released early");

  a_irq_block: assert property (
    wake_isr_r && !wake_reti |=> irq_block)
    else $error("interrupts unblocked before return");
endmodule // power_down_wakeup_ctrl

// ---- bench/wake_side.sv ----
// far-side model: wake pin, usb bus and oscillator watchdog
`timescale 1ns/1ps
module wake_side #(
  parameter int LOW_CYC = 2000
) (
  input  wire logic clk_sys,
  input  wire logic main_osc_en,
  input  wire logic pin_go,
  input  wire logic bus_go,
  output logic      ext_wake_pin,
  output logic      usb_bus_activity,
  output logic      osc_stable
);
  int low_cnt  = 0;
  int act_cnt  = 0;
  int stab_cnt = 0;
  always_ff @(posedge clk_sys) begin
    // pin held low for LOW_CYC cycles from the cycle after pin_go, high otherwise
    low_cnt  <= pin_go ? LOW_CYC : (low_cnt > 0 ? low_cnt - 1 : 0);
    act_cnt  <= bus_go ? 4 : (act_cnt > 0 ? act_cnt - 1 : 0);
    // watchdog reports a stable clock a few cycles after start
    stab_cnt <= main_osc_en ? (stab_cnt < 5 ? stab_cnt + 1 : 5) : 0;
  end
  assign ext_wake_pin     = (low_cnt == 0);
  assign usb_bus_activity = (act_cnt != 0);
  assign osc_stable       = (stab_cnt == 5);
endmodule // wake_side

// ---- bench/power_down_wakeup_ctrl_tb.sv ----
// self-checking bench for the power-down and wake-up controller
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module power_down_wakeup_ctrl_tb;
  import pd_wake_pkg::*;
  localparam int SETTLE = 20;
  localparam int SUSP   = 30;
  // rows: address, write data, value read back
  localparam logic [7:0] RA [10] = '{8'h01, 8'h02, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h06};
  localparam logic [7:0] RW [10] = '{8'h80, 8'h10, 8'h80, 8'h00, 8'h42, 8'h40, 8'h02, 8'h01, 8'h40, 8'hFF};
  localparam logic [7:0] RE [10] = '{8'h00, 8'h10, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  localparam logic [7:0] RS [7]  = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h01, 8'h00, 8'h00};
  logic        clk_sys, sys_rst, reg_wr, reg_rd, ext_wake_latch, wake_reti, pin_go, bus_go;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
  logic [15:0] wake_vector;
  logic        cpu_halt, main_osc_en, rc_osc_en, periph_freeze, irq_block, wake_irq;
  logic        usb_suspend, usb_clk_gate, ext_wake_pin, usb_bus_activity, osc_stable;
  int          err_count   = 0;
  int          checks_done = 0;
  int          n;

  power_down_wakeup_ctrl #(.SETTLE_CYCLES(SETTLE), .SUSPEND_CYCLES(SUSP)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_wake_pin(ext_wake_pin),
    .ext_wake_latch(ext_wake_latch), .usb_bus_activity(usb_bus_activity), .osc_stable(osc_stable),
    .wake_reti(wake_reti), .cpu_halt(cpu_halt), .main_osc_en(main_osc_en), .rc_osc_en(rc_osc_en),
    .periph_freeze(periph_freeze), .irq_block(irq_block), .wake_irq(wake_irq),
    .wake_vector(wake_vector), .usb_suspend(usb_suspend), .usb_clk_gate(usb_clk_gate));
  wake_side #(.LOW_CYC(LATCH_CYC)) far (
    .clk_sys(clk_sys), .main_osc_en(main_osc_en), .pin_go(pin_go), .bus_go(bus_go),
    .ext_wake_pin(ext_wake_pin), .usb_bus_activity(usb_bus_activity), .osc_stable(osc_stable));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // back-to-back writes with no gap, k of them (2 or 3); each word is {addr, data}
  task automatic wr_b2b(input int k, input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w2);
    @(posedge clk_sys);
    reg_wr                <= 1'b1;
    {reg_addr, reg_wdata} <= w0;
    @(posedge clk_sys);
    {reg_addr, reg_wdata} <= w1;
    if (k > 2) begin
      @(posedge clk_sys);
      {reg_addr, reg_wdata} <= w2;
    end
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask
  // 0 pin low, 1 usb activity, 2 handler return
  task automatic pulse(input int w);
    @(posedge clk_sys);
    pin_go    <= (w == 0);
    bus_go    <= (w == 1);
    wake_reti <= (w == 2);
    @(posedge clk_sys);
    {pin_go, bus_go, wake_reti} <= 3'b000;
    // step off the edge so callers see settled outputs
    #1;
  endtask
  function automatic logic sel(input int w);
    case (w)
      0: return rc_osc_en;
      1: return main_osc_en;
      2: return osc_stable;
      3: return wake_irq;
      4: return usb_suspend;
      default: return !usb_bus_activity;
    endcase
  endfunction
  // bounded wait; n holds the cycles spent
  task automatic wait_hi(input int w, input int lim);
    n = 0;
    while (sel(w) !== 1'b1 && n < lim) begin
      cyc();
      n++;
    end
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask
  task automatic chk_regs();
    for (int i = 0; i < 7; i++) begin
      rd(8'(i), v);
      `CHK(v, RS[i])
    end
  endtask
  task automatic enter_pd();
    wr_b2b(2, 16'h0002, 16'h0040, 16'h0000);
    cyc();
    cyc();
  endtask
  task automatic finish_wake();
    wait_hi(3, 2100);
    `CHK({wake_irq, cpu_halt, irq_block, periph_freeze}, 4'b1011)
    pulse(2);
    cyc();
    cyc();
    `CHK({wake_irq, cpu_halt, irq_block, periph_freeze}, 4'b0000)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #150000;
    err_count++;
    wrap_up();
  end
  initial begin
    {sys_rst, reg_wr, reg_rd, wake_reti, pin_go, bus_go} = 6'b100000;
    ext_wake_latch = 1'b1;
    reg_addr       = 8'h00;
    reg_wdata      = 8'h00;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    chk_regs();
    for (int i = 0; i < 10; i++) begin
      wr(RA[i], RW[i]);
      rd(RA[i], v);
      `CHK(v, RE[i])
      `CHK(cpu_halt, 1'b0)
    end
    // arm, foreign write, start with no gaps: the arm must be gone
    wr_b2b(3, 16'h0002, 16'h0301, 16'h0040);
    cyc();
    cyc();
    `CHK(cpu_halt, 1'b0)
    // pin wake with full latch timing and a 20-cycle settle
    enter_pd();
    `CHK({cpu_halt, main_osc_en, rc_osc_en, periph_freeze}, 4'b1001)
    pulse(0);
    wait_hi(0, 10);
    `CHK({irq_block, main_osc_en, periph_freeze}, 3'b101)
    wait_hi(1, 3000);
    `CHK(n, LATCH_CYC)
    wait_hi(2, 20);
    wait_hi(3, 100);
    `CHK(n, SETTLE + 1)
    `CHK(wake_vector, 16'h007B)
    finish_wake();
    // latch left low: wake starts at once
    @(posedge clk_sys);
    ext_wake_latch <= 1'b0;
    enter_pd();
    `CHK({cpu_halt, rc_osc_en}, 2'b11)
    @(posedge clk_sys);
    ext_wake_latch <= 1'b1;
    finish_wake();
    wr(8'h03, 8'h03);
    cyc();
    `CHK(usb_clk_gate, 1'b1)
    wr(8'h03, 8'h01);
    // usb wake
    wr(8'h02, 8'h10);
    wr(8'h01, 8'h90);
    wr(8'h02, 8'h00);
    wr(8'h04, 8'h00);
    pulse(1);
    wait_hi(5, 10);
    `CHK(usb_suspend, 1'b0)
    wait_hi(4, 100);
    `CHK(n > SUSP && n <= SUSP + 2, 1'b1)
    enter_pd();
    pulse(1);
    wait_hi(1, 5);
    `CHK({main_osc_en, usb_suspend, irq_block}, 3'b101)
    finish_wake();
    // receiver powered down: activity must not wake
    wr(8'h04, 8'h01);
    wait_hi(4, 100);
    enter_pd();
    pulse(1);
    repeat (20) cyc();
    `CHK({cpu_halt, main_osc_en}, 2'b10)
    // wake disabled: only reset leaves power-down
    do_reset();
    chk_regs();
    enter_pd();
    pulse(0);
    repeat (2100) cyc();
    `CHK({cpu_halt, rc_osc_en}, 2'b10)
    do_reset();
    cyc();
    `CHK({cpu_halt, main_osc_en, rc_osc_en, periph_freeze}, 4'b0110)
    wrap_up();
  end
endmodule // power_down_wakeup_ctrl_tb
